// ---- dv/ods_host_model.sv ----
// Host controller model: sends 24-bit serial frames into the sequencer.
// Assumes it shares i_clk with the device and sees the reset pin.
`timescale 1ns/10ps
module ods_host_model
  import ods_pkg::*;
#(
  parameter int QUIET_GAP = 20,
  parameter int CAL_GAP = 30
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  output logic o_sclk,
  output logic o_sdi,
  output logic o_sync_n
);
  int cyc = 0;
  int rst_mark = 0;
  int cal_mark = -100000;
  logic idle = 1'b1;

  initial begin
    o_sclk = 1'b1;
    o_sdi = 1'b0;
    o_sync_n = 1'b1;
  end

  // ==========================================================
  // Cycle count, reset mark and idle data pattern
  // A released data line toggles so a stale bit is never read
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (!i_resetn) rst_mark <= cyc;
    if (idle) o_sdi <= ~o_sdi;
  end

  // ==========================================================
  // Frame sender; ph sets cycles per clock phase (prompt or slow)
  task automatic send_frame(input logic [23:0] word, input int ph);
    while (cyc - rst_mark < QUIET_GAP + 4 || cyc - cal_mark < CAL_GAP + 4)
      @(posedge i_clk);
    @(posedge i_clk);
    idle <= 1'b0;
    o_sync_n <= 1'b0;
    // MSB first, valid across the fall
    for (int i = 23; i >= 0; i--) begin
      @(posedge i_clk);
      o_sclk <= 1'b1;
      o_sdi <= word[i];
      repeat (ph) @(posedge i_clk);
      o_sclk <= 1'b0;
      repeat (ph - 1) @(posedge i_clk);
    end
    @(posedge i_clk);
    o_sync_n <= 1'b1;
    o_sclk <= 1'b1;
    idle <= 1'b1;
    if (word[15:0] == CMD_CAL_REFRESH) cal_mark <= cyc;
  endtask : send_frame
endmodule : ods_host_model

// ---- dv/ods_sequencer_test.sv ----
// Self-checking bench for the output converter reset sequencer.
// Assumes the host model drives the serial pins; port tasks do the rest.
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin n_tests++; if ((got) !== (ex)) begin \
  bad_count++; $display("Error %s expected %h seen %h", nm, ex, got); \
  end end
module ods_sequencer_test import ods_pkg::*;;
  localparam int QUIET = 20;
  localparam int CAL = 30;
  localparam int SWH = 4;
  localparam int LIMIT = 20000;
  logic i_clk = 1'b0;
  logic i_resetn = 1'b0;
  logic i_ldo_ok = 1'b1;
  logic i_avcc_ok = 1'b1;
  logic i_over_current = 1'b0;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic [7:0] i_addr = 8'h00;
  logic [15:0] i_wdata = 16'h0000;
  logic sclk, sdi, sync_n, o_cmd_ready, o_vout_en, o_iout_en;
  logic o_pulldown_close, o_rail_hold_4v8, o_reg_sw, o_fault, lvl;
  logic [15:0] o_rdata, code;
  logic [4:0] o_rail_target;
  logic signed [15:0] o_vout_steps;
  logic [15:0] corner [5] = '{16'h0000, 16'h0001, 16'h7FFF, 16'h8000,
    16'hFFFF};
  int bad_count = 0;
  int n_tests = 0;
  int cyc = 0;
  int seed = 877;
  int n;

  always #5 i_clk = ~i_clk;

  ods_sequencer #(.QUIET_CYCLES(QUIET), .CAL_CYCLES(CAL), .SW_HALF(SWH))
    u_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_ldo_ok(i_ldo_ok),
    .i_avcc_ok(i_avcc_ok), .i_over_current(i_over_current),
    .i_sclk(sclk), .i_sdi(sdi), .i_sync_n(sync_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .o_cmd_ready(o_cmd_ready), .o_vout_en(o_vout_en),
    .o_iout_en(o_iout_en), .o_pulldown_close(o_pulldown_close),
    .o_rail_hold_4v8(o_rail_hold_4v8), .o_reg_sw(o_reg_sw),
    .o_rail_target(o_rail_target), .o_fault(o_fault),
    .o_vout_steps(o_vout_steps));

  ods_host_model #(.QUIET_GAP(QUIET), .CAL_GAP(CAL)) u_host (
    .i_clk(i_clk), .i_resetn(i_resetn), .o_sclk(sclk), .o_sdi(sdi),
    .o_sync_n(sync_n));

  // ==========================================================
  // Expected output steps: 0x8000 is zero, one step per code
  function automatic logic signed [15:0] exp_steps(input logic [15:0] c);
    return c - 16'h8000;
  endfunction : exp_steps

  // ==========================================================
  // Register port tasks; strobes rise on a fresh edge every time
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
  endtask : wr

  task automatic chk_reg(input logic [7:0] a, input logic [15:0] ex,
    input string nm);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    #1;
    `CHK(nm, ex, o_rdata)
  endtask : chk_reg

  // Bounded wait for writes to be accepted again
  // lo is the least wait still ahead when the call starts
  task automatic wait_ready(input int lo = QUIET);
    n = 0;
    while (o_cmd_ready !== 1'b1 && n < 1000) begin
      @(posedge i_clk);
      #1 n++;
    end
    `CHK("quiet_len", 1'b1, n >= lo)
  endtask : wait_ready

  // Output state that every reset source must leave behind
  task automatic chk_defaults();
    `CHK("vout_en", 1'b0, o_vout_en)
    `CHK("iout_en", 1'b0, o_iout_en)
    `CHK("pulldown", 1'b0, o_pulldown_close)
    `CHK("rail_hold", 1'b1, o_rail_hold_4v8)
    `CHK("cmd_ready", 1'b0, o_cmd_ready)
    `CHK("fault", 1'b0, o_fault)
  endtask : chk_defaults

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : complete_run

  // Hang guard: a run past the ceiling counts as a mismatch
  always @(posedge i_clk) begin
    cyc <= cyc + 1;
    if (cyc == LIMIT) begin
      bad_count++;
      complete_run();
    end
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    #1 chk_defaults();
    wait_ready();
    chk_reg(ADR_STATUS, 16'h0022, "status_wait");
    chk_reg(ADR_DAC_CODE, RST_DAC_CODE, "dac_rst");
    chk_reg(8'h3C, 16'h0000, "unmapped");
    wr(ADR_OUT_CTRL, 16'h0003);
    #1 `CHK("early_en", 1'b0, o_vout_en)
    for (int p = 0; p < 2; p++) begin
      // refresh sent serially, prompt then after pin reset
      u_host.send_frame({ADR_COMMAND, CMD_CAL_REFRESH}, 1);
      repeat (CAL + 4) @(posedge i_clk);
      chk_reg(ADR_STATUS, 16'h0024, "status_ready");
      if (p == 1) break;
      wr(ADR_OUT_CTRL, 16'h0001);
      #1 `CHK("vout_on", 1'b1, o_vout_en)
      // pull-down via a slow serial frame
      u_host.send_frame({ADR_SETUP_TWO, 16'h0001}, 3);
      repeat (2) @(posedge i_clk);
      #1 `CHK("pulldown_on", 1'b1, o_pulldown_close)
      wr(ADR_SETUP_ONE, 16'h0001);
      repeat (2) @(posedge i_clk);
      #1 `CHK("rail_free", 1'b0, o_rail_hold_4v8)
      `CHK("dyn_on", RAIL_DYN_CODE, o_rail_target)
      wr(ADR_OUT_CTRL, 16'h0000);
      repeat (2) @(posedge i_clk);
      #1 `CHK("dyn_off", RAIL_DYN_CODE, o_rail_target)
      // fixed half period, no fault at light load
      for (int k = 0; k < 4; k++) begin
        n = 0;
        lvl = o_reg_sw;
        while (o_reg_sw === lvl && n < 100) begin
          @(posedge i_clk);
          #1 n++;
        end
        if (k > 0) `CHK("sw_half", SWH, n)
      end
      `CHK("no_fault", 1'b0, o_fault)
      // A real current limit must still reach the fault output
      i_over_current <= 1'b1;
      repeat (2) @(posedge i_clk);
      #1 `CHK("fault_on", 1'b1, o_fault)
      i_over_current <= 1'b0;
      repeat (2) @(posedge i_clk);
      wr(ADR_SETUP_ONE, 16'h004F);
      repeat (2) @(posedge i_clk);
      #1 `CHK("fixed_lvl", 5'h13, o_rail_target)
      for (int i = 0; i < 13; i++) begin
        code = (i < 5) ? corner[i] : 16'($random(seed));
        wr(ADR_DAC_CODE, code);
        repeat (2) @(posedge i_clk);
        #1 `CHK("steps", exp_steps(code), o_vout_steps)
      end
      wr(ADR_COMMAND, CMD_SOFT_RESET);
      repeat (3) @(posedge i_clk);
      #1 chk_defaults();
      chk_reg(ADR_SETUP_TWO, RST_SETUP_TWO, "soft_s2");
      chk_reg(ADR_DAC_CODE, RST_DAC_CODE, "soft_dac");
      // Quiet window began six edges before this point
      wait_ready(QUIET - 6);
      // each supply flag low holds reset
      for (int s = 0; s < 2; s++) begin
        wr(ADR_SETUP_TWO, 16'h0001);
        if (s == 0) i_ldo_ok <= 1'b0;
        else i_avcc_ok <= 1'b0;
        repeat (2) @(posedge i_clk);
        #1 chk_defaults();
        chk_reg(ADR_STATUS, 16'h0020, "low_hold");
        i_ldo_ok <= 1'b1;
        i_avcc_ok <= 1'b1;
        wait_ready();
        chk_reg(ADR_SETUP_TWO, RST_SETUP_TWO, "low_s2");
      end
      wr(ADR_SETUP_TWO, 16'h0001);
      wr(ADR_DAC_CODE, 16'h1234);
      @(posedge i_clk);
      i_resetn <= 1'b0;
      repeat (2) @(posedge i_clk);
      #1 chk_defaults();
      i_resetn <= 1'b1;
      wait_ready();
      chk_reg(ADR_DAC_CODE, RST_DAC_CODE, "pin_dac");
    end
    complete_run();
  end
endmodule : ods_sequencer_test

// ---- hdl/ods_pkg.sv ----
// Shared constants for the output converter reset sequencer.
// Assumes a 100 MHz core clock and 16-bit register words.
package ods_pkg;

  // ==========================================================
  // Widths
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  localparam int CNT_W = 16;
  localparam int SW_W = 8;
  localparam int FRAME_LEN = 24;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADR_DAC_CODE = 8'h00;
  localparam logic [7:0] ADR_OUT_CTRL = 8'h01;
  localparam logic [7:0] ADR_SETUP_ONE = 8'h02;
  localparam logic [7:0] ADR_SETUP_TWO = 8'h03;
  localparam logic [7:0] ADR_COMMAND = 8'h04;
  localparam logic [7:0] ADR_STATUS = 8'h05;

  // ==========================================================
  // Field positions and masks
  localparam int OUT_VOUT_BIT = 0;
  localparam int OUT_IOUT_BIT = 1;
  localparam int S1_REG_EN_BIT = 0;
  localparam int S1_MODE_BIT = 1;
  localparam int S1_LEVEL_LSB = 2;
  localparam int S1_LEVEL_W = 5;
  localparam int S2_PULLDN_BIT = 0;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_REG_RUN_BIT = 3;
  localparam int ST_FAULT_BIT = 4;
  localparam int ST_RAIL_HOLD_BIT = 5;
  localparam logic [15:0] OUT_MASK = 16'h0003;
  localparam logic [15:0] S1_MASK = 16'h007F;
  localparam logic [15:0] S2_MASK = 16'h0001;

  // ==========================================================
  // Reset values and codes
  localparam logic [15:0] RST_DAC_CODE = 16'h8000;
  localparam logic [15:0] RST_OUT_CTRL = 16'h0000;
  localparam logic [15:0] RST_SETUP_ONE = 16'h0000;
  localparam logic [15:0] RST_SETUP_TWO = 16'h0000;
  localparam logic [15:0] MID_CODE = 16'h8000;
  localparam logic [15:0] CMD_CAL_REFRESH = 16'hCA1F;
  localparam logic [15:0] CMD_SOFT_RESET = 16'h5AA5;
  // Level code standing for 15 V above the negative sense input
  localparam logic [4:0] RAIL_DYN_CODE = 5'h0F;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int T_QUIET_US = 100;
  localparam int T_CAL_US = 500;
  localparam int SW_FREQ_KHZ = 500;
  // Least times round up to whole cycles
  localparam int QUIET_CYC =
    (T_QUIET_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int CAL_CYC =
    (T_CAL_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SW_HALF_CYC =
    1000000 / (2 * SW_FREQ_KHZ * CLK_PERIOD_NS);

  // ==========================================================
  // Types
  typedef enum logic [0:0] {
    MODE_DYNAMIC,
    MODE_FIXED
  } ods_mode_t;

  typedef enum logic [2:0] {
    ST_HOLD,
    ST_QUIET,
    ST_AWAIT_CAL,
    ST_CALIBRATING,
    ST_READY
  } ods_state_t;

endpackage : ods_pkg

// ---- hdl/ods_sequencer.sv ----
// Reset, calibration and supply sequencing of a single-channel
// voltage/current output converter, with its register file.
// Assumes all inputs synchronous to i_clk; supply-good flags come
// from analog comparators; the host writes serial frames or the port.
//
// Overview of operation
// - Bipolar 5 V range codes are straight binary, 0x8000 is zero.
// - Voltage and current outputs are off after any reset.
// - The output pull-down switch is open after any reset.
// - The pull-down switch follows a field of setup register two.
// - The driver rail is held at its 4.8 V level until the regulator runs.
// - Reset holds while either internal supply is too low.
// - The reset pin and a software reset command both reset the block.
// - The regulator switches at a fixed 500 kHz and never skips.
// - A driver rail above target at light load is not a fault.
// - Dynamic mode regulates the rail to 15 V over the sense input.
// - Serial bits are taken on the falling clock edge, MSB first.
//
// The placing of the registers and the plain strobed port were left to the implementer.
`timescale 1ns/10ps
module ods_sequencer
  import ods_pkg::*;
#(
  parameter int QUIET_CYCLES = QUIET_CYC,
  parameter int CAL_CYCLES = CAL_CYC,
  parameter int SW_HALF = SW_HALF_CYC
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_ldo_ok,
  input wire logic i_avcc_ok,
  input wire logic i_over_current,
  input wire logic i_sclk,
  input wire logic i_sdi,
  input wire logic i_sync_n,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  output logic o_cmd_ready,
  output logic o_vout_en,
  output logic o_iout_en,
  output logic o_pulldown_close,
  output logic o_rail_hold_4v8,
  output logic o_reg_sw,
  output logic [S1_LEVEL_W-1:0] o_rail_target,
  output logic o_fault,
  output logic signed [DATA_W-1:0] o_vout_steps
);

  if (QUIET_CYCLES < 1 || QUIET_CYCLES >= 2 ** CNT_W ||
      CAL_CYCLES < 1 || CAL_CYCLES >= 2 ** CNT_W) begin : g_bad_cnt
    $error("Quiet and calibration counts must fit the counter");
  end
  if (SW_HALF < 2 || SW_HALF >= 2 ** SW_W) begin : g_bad_sw
    $error("Switching half period must fit the counter");
  end

  localparam logic [CNT_W-1:0] QUIET_INIT = CNT_W'(QUIET_CYCLES - 1);
  localparam logic [CNT_W-1:0] CAL_INIT = CNT_W'(CAL_CYCLES - 1);
  localparam logic [SW_W-1:0] SW_LAST = SW_W'(SW_HALF - 1);

  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] t);
    hit = (a == t);
  endfunction : hit

  ods_state_t state_ff;
  ods_state_t nxt_state;
  logic [CNT_W-1:0] cnt_ff;
  logic [CNT_W-1:0] nxt_cnt;
  logic [DATA_W-1:0] dac_code_ff;
  logic [DATA_W-1:0] out_ctrl_ff;
  logic [DATA_W-1:0] setup_one_ff;
  logic [DATA_W-1:0] setup_two_ff;
  logic [DATA_W-1:0] rdata_ff;
  logic [SW_W-1:0] sw_cnt_ff;
  logic sw_ff;
  logic soft_rst_ff;
  logic fault_ff;
  logic hold_ff;
  logic [S1_LEVEL_W-1:0] target_ff;
  logic signed [DATA_W-1:0] steps_ff;

  logic rx_valid;
  logic [ADDR_W-1:0] rx_addr;
  logic [DATA_W-1:0] rx_data;

  // ==========================================================
  // Reset sources and write path
  // supplies gate reset release
  logic supply_ok;
  logic sync_clr;
  logic accept;
  logic ready;
  logic wr_en;
  logic [ADDR_W-1:0] wr_addr;
  logic [DATA_W-1:0] wr_data;
  // soft reset joins the supply-low clear path (sync_clr), not the pin reset
  assign supply_ok = i_ldo_ok & i_avcc_ok;
  assign sync_clr = ~supply_ok | soft_rst_ff;
  assign ready = (state_ff == ST_READY);
  // writes inside the quiet window are dropped
  assign accept = (state_ff != ST_HOLD) && (state_ff != ST_QUIET);
  // Port write wins when both sources land in one cycle
  assign wr_en = accept & (i_wr | rx_valid);
  assign wr_addr = i_wr ? i_addr : rx_addr;
  assign wr_data = i_wr ? i_wdata : rx_data;

  // Write decode
  logic wr_dac;
  logic wr_out;
  logic wr_s1;
  logic wr_s2;
  logic wr_cmd;
  logic cmd_cal;
  logic cmd_soft;
  assign wr_dac = wr_en & hit(wr_addr, ADR_DAC_CODE);
  // enables only take writes once calibrated
  assign wr_out = wr_en & ready & hit(wr_addr, ADR_OUT_CTRL);
  assign wr_s1 = wr_en & ready & hit(wr_addr, ADR_SETUP_ONE);
  assign wr_s2 = wr_en & hit(wr_addr, ADR_SETUP_TWO);
  assign wr_cmd = wr_en & hit(wr_addr, ADR_COMMAND);
  assign cmd_cal = wr_cmd & (wr_data == CMD_CAL_REFRESH);
  assign cmd_soft = wr_cmd & (wr_data == CMD_SOFT_RESET);

  ods_serial_rx #(
    .FRAME_BITS(FRAME_LEN)
  ) u_rx (
    .i_clk(i_clk),
    .i_resetn(i_resetn),
    .i_clear(sync_clr),
    .i_sclk(i_sclk),
    .i_sdi(i_sdi),
    .i_sync_n(i_sync_n),
    .o_valid(rx_valid),
    .o_addr(rx_addr),
    .o_data(rx_data)
  );

  // ==========================================================
  // Sequencing state machine
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      ST_HOLD: begin
        nxt_state = ST_QUIET;
        nxt_cnt = QUIET_INIT;
      end
      ST_QUIET: begin
        if (cnt_ff == '0) begin
          nxt_state = ST_AWAIT_CAL;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      ST_AWAIT_CAL, ST_READY: begin
        if (cmd_cal) begin
          nxt_state = ST_CALIBRATING;
          nxt_cnt = CAL_INIT;
        end
      end
      ST_CALIBRATING: begin
        if (cnt_ff == '0) begin
          nxt_state = ST_READY;
        end else begin
          nxt_cnt = cnt_ff - 1'b1;
        end
      end
      default: begin
        nxt_state = ST_HOLD;
      end
    endcase
    if (!supply_ok) begin
      nxt_state = ST_HOLD;
      nxt_cnt = '0;
    end else if (soft_rst_ff) begin
      nxt_state = ST_QUIET;
      nxt_cnt = QUIET_INIT;
    end
  end

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_ff <= ST_HOLD;
      cnt_ff <= '0;
      soft_rst_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      soft_rst_ff <= cmd_soft & supply_ok;
    end
  end

  // ==========================================================
  // Configuration registers
  // every reset source restores defaults
  // outputs off and pull-down open by default
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      dac_code_ff <= RST_DAC_CODE;
      out_ctrl_ff <= RST_OUT_CTRL;
      setup_one_ff <= RST_SETUP_ONE;
      setup_two_ff <= RST_SETUP_TWO;
    end else if (sync_clr) begin
      dac_code_ff <= RST_DAC_CODE;
      out_ctrl_ff <= RST_OUT_CTRL;
      setup_one_ff <= RST_SETUP_ONE;
      setup_two_ff <= RST_SETUP_TWO;
    end else begin
      if (wr_dac) dac_code_ff <= wr_data;
      if (wr_out) out_ctrl_ff <= wr_data & OUT_MASK;
      if (wr_s1) setup_one_ff <= wr_data & S1_MASK;
      if (wr_s2) setup_two_ff <= wr_data & S2_MASK;
    end
  end

  // ==========================================================
  // Output stage supply regulator
  logic reg_run;
  logic mode_fixed;
  assign reg_run = setup_one_ff[S1_REG_EN_BIT];
  assign mode_fixed = (setup_one_ff[S1_MODE_BIT] == MODE_FIXED);

  // free running switching clock
  // No pulse skipping: the counter never waits on load conditions
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sw_cnt_ff <= '0;
      sw_ff <= 1'b0;
    end else if (!reg_run) begin
      sw_cnt_ff <= '0;
      sw_ff <= 1'b0;
    end else if (sw_cnt_ff == SW_LAST) begin
      sw_cnt_ff <= '0;
      sw_ff <= ~sw_ff;
    end else begin
      sw_cnt_ff <= sw_cnt_ff + 1'b1;
    end
  end

  // Rail control, fault and output code
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      hold_ff <= 1'b1;
      target_ff <= RAIL_DYN_CODE;
      fault_ff <= 1'b0;
      steps_ff <= '0;
    end else begin
      // internal 4.8 V drive until regulator runs
      hold_ff <= ~reg_run;
      target_ff <= mode_fixed ?
        setup_one_ff[S1_LEVEL_LSB +: S1_LEVEL_W] : RAIL_DYN_CODE;
      // rail overshoot has no fault path
      fault_ff <= reg_run & i_over_current;
      steps_ff <= $signed(dac_code_ff ^ MID_CODE);
    end
  end

  // ==========================================================
  // Read port
  logic [DATA_W-1:0] status_word;
  logic [DATA_W-1:0] rd_word;
  assign status_word = {10'h000, hold_ff, fault_ff, reg_run, state_ff};
  // Unmapped offsets read as zero
  assign rd_word =
    hit(i_addr, ADR_DAC_CODE) ? dac_code_ff :
    hit(i_addr, ADR_OUT_CTRL) ? out_ctrl_ff :
    hit(i_addr, ADR_SETUP_ONE) ? setup_one_ff :
    hit(i_addr, ADR_SETUP_TWO) ? setup_two_ff :
    hit(i_addr, ADR_STATUS) ? status_word : '0;

  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      rdata_ff <= '0;
    end else if (i_rd) begin
      rdata_ff <= rd_word;
    end
  end

  assign o_rdata = rdata_ff;
  assign o_cmd_ready = accept;
  assign o_vout_en = out_ctrl_ff[OUT_VOUT_BIT];
  assign o_iout_en = out_ctrl_ff[OUT_IOUT_BIT];
  assign o_pulldown_close = setup_two_ff[S2_PULLDN_BIT];
  assign o_rail_hold_4v8 = hold_ff;
  assign o_reg_sw = sw_ff;
  assign o_rail_target = target_ff;
  assign o_fault = fault_ff;
  assign o_vout_steps = steps_ff;

  // ==========================================================
  // Checks
  localparam int A_SW = SW_HALF;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_zero_code_map: assert property (
    (wr_dac && !sync_clr && wr_data == MID_CODE) |=> ##1 (o_vout_steps == 0))
    else $error("mid code does not give zero output");
  a_outputs_off: assert property (
    sync_clr |=> (!o_vout_en && !o_iout_en))
    else $error("output path enabled after reset");
  a_pulldown_open: assert property (
    sync_clr |=> !o_pulldown_close)
    else $error("pull-down closed after reset");
  a_pulldown_field: assert property (
    (wr_s2 && !sync_clr) |=>
      (o_pulldown_close == $past(wr_data[S2_PULLDN_BIT])))
    else $error("pull-down does not follow its field");
  a_rail_hold: assert property (
    !reg_run |=> o_rail_hold_4v8)
    else $error("rail not held while regulator off");
  a_supply_hold: assert property (
    !supply_ok |=> (state_ff == ST_HOLD && !o_cmd_ready))
    else $error("reset released with low supplies");
  a_soft_reset_cfg: assert property (
    (cmd_soft && supply_ok) |=> ##1 (state_ff == ST_QUIET &&
      setup_one_ff == RST_SETUP_ONE && setup_two_ff == RST_SETUP_TWO))
    else $error("soft reset did not restore defaults");
  a_quiet_drop: assert property (
    (state_ff == ST_QUIET) |-> !wr_en)
    else $error("write taken in quiet window");
  a_sw_no_skip: assert property (
    (reg_run && $changed(sw_ff)) |->
      ##[1:A_SW] ($changed(sw_ff) || !reg_run))
    else $error("switching edge skipped");
  a_no_rail_fault: assert property (
    !i_over_current |=> !o_fault)
    else $error("fault without over-current cause");
  a_dyn_target: assert property (
    (!mode_fixed) |=> (o_rail_target == RAIL_DYN_CODE))
    else $error("dynamic mode rail target wrong");
  a_enable_gate: assert property (
    (!ready && !sync_clr) |=> (out_ctrl_ff == $past(out_ctrl_ff) &&
      setup_one_ff == $past(setup_one_ff)))
    else $error("enable written before calibration");
  a_cal_finish: assert property (
    (state_ff == ST_CALIBRATING && cnt_ff == '0 && supply_ok &&
      !soft_rst_ff) |=> ready)
    else $error("calibration did not complete");

  c_cal_done: cover property (state_ff == ST_CALIBRATING ##1 ready);
  c_soft_reset: cover property (cmd_soft);
  c_sw_toggle: cover property (reg_run && $rose(sw_ff));
  c_serial_write: cover property (rx_valid && wr_en && !i_wr);

endmodule : ods_sequencer

// ---- hdl/ods_serial_rx.sv ----
// Serial frame receiver: address byte then data word, MSB first.
// Assumes serial pins already synchronous to i_clk, clock idle high.
`timescale 1ns/10ps
module ods_serial_rx
  import ods_pkg::*;
#(
  parameter int FRAME_BITS = FRAME_LEN
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_clear,
  input wire logic i_sclk,
  input wire logic i_sdi,
  input wire logic i_sync_n,
  output logic o_valid,
  output logic [ADDR_W-1:0] o_addr,
  output logic [DATA_W-1:0] o_data
);

  localparam int BW = $clog2(FRAME_BITS + 2);

  if (FRAME_BITS != ADDR_W + DATA_W) begin : g_bad_frame
    $error("Frame length must equal address plus data width");
  end

  logic sclk_ff;
  logic sync_n_ff;
  logic valid_ff;
  logic [FRAME_BITS-1:0] sh_ff;
  logic [BW-1:0] bits_ff;
  logic fall;
  logic frame_end;
  logic full_frame;

  // ==========================================================
  // Edge and frame detection
  assign fall = sclk_ff & ~i_sclk & ~i_sync_n;
  assign frame_end = ~sync_n_ff & i_sync_n;
  assign full_frame = (bits_ff == BW'(FRAME_BITS));

  // Previous pin levels
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sclk_ff <= 1'b1;
      sync_n_ff <= 1'b1;
    end else begin
      sclk_ff <= i_sclk;
      sync_n_ff <= i_sync_n;
    end
  end

  // falling edge capture
  // Shifting in at the LSB keeps the first bit on top of the word
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      sh_ff <= '0;
      bits_ff <= '0;
    end else if (i_clear || i_sync_n) begin
      bits_ff <= '0;
    end else if (fall) begin
      sh_ff <= {sh_ff[FRAME_BITS-2:0], i_sdi};
      if (bits_ff <= BW'(FRAME_BITS)) begin
        bits_ff <= bits_ff + 1'b1;
      end
    end
  end

  // Short or long frames are dropped silently
  always_ff @(posedge i_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      valid_ff <= 1'b0;
    end else begin
      valid_ff <= frame_end & full_frame & ~i_clear;
    end
  end

  assign o_valid = valid_ff;
  assign o_addr = sh_ff[FRAME_BITS-1:DATA_W];
  assign o_data = sh_ff[DATA_W-1:0];

  // ==========================================================
  // Checks
  default clocking cb_rx @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  a_msb_first_shift: assert property (
    (fall && !i_clear && !i_sync_n) |=>
      (sh_ff[0] == $past(i_sdi)) &&
      (sh_ff[FRAME_BITS-1:1] == $past(sh_ff[FRAME_BITS-2:0])))
    else $error("serial bit not shifted in msb first");

  c_frame_taken: cover property (o_valid);

endmodule : ods_serial_rx
